// ### design/wtpg_pkg.sv
// constants, register map and carrier types for the wan test pattern block
// assumes a single 40 mhz clock and a plain strobe register port
package wtpg_pkg;

   // =====================================================================
   // bus and datapath widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int COUNT_W = 16;

   // =====================================================================
   // register offsets
   localparam logic [7:0] OFS_TEST_CONTROL = 8'h00;
   localparam logic [7:0] OFS_TEST_STATUS = 8'h01;
   localparam logic [7:0] OFS_TRANSMIT_CONTROL = 8'h02;
   localparam logic [7:0] OFS_SECTION_COUNT = 8'h03;
   localparam logic [7:0] OFS_LINE_COUNT = 8'h04;
   localparam logic [7:0] OFS_PATH_COUNT = 8'h05;
   localparam logic [7:0] OFS_PRBS_COUNT = 8'h06;
   localparam logic [7:0] OFS_PRBS_STATUS = 8'h07;
   localparam logic [7:0] OFS_MONITOR_TICK = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h09;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0a;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0b;

   // =====================================================================
   // field positions
   localparam int CTL_SQ_SEL = 0;
   localparam int CTL_GEN_EN = 1;
   localparam int CTL_CHK_EN = 2;
   localparam int CTL_PRBS_GEN = 3;
   localparam int CTL_PRBS_CHK = 4;
   localparam int STS_CAPABILITY = 0;
   localparam int PST_ERROR = 0;
   localparam int PST_LOCKED = 1;
   localparam int TXC_PW_LSB = 0;
   localparam int TXC_PW_W = 8;
   localparam int TXC_MODE_LSB = 8;
   localparam int TICK_INJECT = 0;
   localparam int IRQ_W = 3;
   localparam int IRQ_PRBS_ERR = 0;
   localparam int IRQ_LOCK = 1;
   localparam int IRQ_MIX_ERR = 2;

   // =====================================================================
   // reset values and pattern constants
   localparam logic [15:0] TXC_RESET = 16'h0004;
   localparam logic [15:0] MIXED_WORD = 16'h0f35;
   localparam logic [15:0] TSS_WORD = 16'h5a3c;
   localparam logic [30:0] PRBS_SEED = 31'h7fffffff;
   localparam int PRBS_TAP_A = 30;
   localparam int PRBS_TAP_B = 27;
   localparam int CID_RUN = 72;
   localparam int LOCK_LEN = 31;

   // =====================================================================
   // types
   typedef enum logic [1:0] {WTPG_MODE_NONE, WTPG_MODE_TSS, WTPG_MODE_CID, WTPG_MODE_SPARE}
      wtpg_mode_t;
   typedef enum logic [2:0] {SRC_LINE, SRC_SQUARE, SRC_MIXED, SRC_PRBS, SRC_TSS, SRC_CID}
      wtpg_src_t;

   typedef struct packed {
      logic prbs_chk;
      logic prbs_gen;
      logic chk_en;
      logic gen_en;
      logic sq_sel;
   } wtpg_ctrl_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } wtpg_bus_t;

endpackage : wtpg_pkg

// ### design/wtpg_prbs_checker.sv
// self-synchronising prbs31 checker for one serial receive bit per clock
// assumes rx bits are synchronous to ref_clk and qualified by rx_valid
`timescale 1ns/1ps
`default_nettype none
module wtpg_prbs_checker
   import wtpg_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic enable,
   // receive stream
   input wire logic rx_valid,
   input wire logic rx_bit,
   // results
   output logic err_q,
   output logic locked_q
);
   import wtpg_pkg::*;

   logic [30:0] hist_q;
   logic [5:0] run_q;
   wire logic predicted;
   wire logic mismatch;

   // =====================================================================
   // prediction from received taps
   assign predicted = hist_q[PRBS_TAP_A] ^ hist_q[PRBS_TAP_B];
   assign mismatch = rx_bit ^ predicted;

   // =====================================================================
   // runs only when enabled
   always_ff @(posedge ref_clk)
   begin
      if (rst || !enable)
      begin
         hist_q <= '0;
         run_q <= '0;
         locked_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         err_q <= rx_valid && locked_q && mismatch;
         if (rx_valid)
         begin
            hist_q <= {hist_q[29:0], rx_bit};
            run_q <= mismatch ? 6'h00 : run_q + 6'h01;
            // lock after a clean run; stays locked so bursts keep counting
            if (!mismatch && run_q >= 6'(LOCK_LEN - 1))
            begin
               locked_q <= 1'b1;
            end
         end
      end
   end

endmodule : wtpg_prbs_checker
`default_nettype wire

// ### design/wtpg_core.sv
// wan test pattern generator and checker, serial one bit per clock
// assumes a 40 mhz ref_clk, synchronous reset and a strobe register port
`timescale 1ns/1ps
`default_nettype none
module wtpg_core
   import wtpg_pkg::*;
#(
   parameter int CNT_W = COUNT_W
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire wtpg_pkg::wtpg_bus_t bus,
   output logic [wtpg_pkg::DATA_W-1:0] rdata_q,
   // transmit line
   input wire logic tx_line_bit,
   output logic tx_bit_q,
   output logic tx_test_active,
   // receive line
   input wire logic rx_valid,
   input wire logic rx_bit,
   // interrupt
   output logic irq
);
   import wtpg_pkg::*;

   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   // =====================================================================
   // registers
   wtpg_ctrl_t ctrl_q;
   logic [15:0] txc_q;
   logic [IRQ_W-1:0] irq_sts_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic inject_q;
   logic [CNT_W-1:0] prbs_cnt_q;
   logic [CNT_W-1:0] par_cnt_q [3];
   wtpg_src_t src_q;

   // =====================================================================
   // address decode
   wire logic [TXC_PW_W-1:0] pw = txc_q[TXC_PW_LSB +: TXC_PW_W];
   wire wtpg_mode_t mode = wtpg_mode_t'(txc_q[TXC_MODE_LSB +: 2]);
   wire logic wr_ctl = bus.wr && bus.addr == OFS_TEST_CONTROL;
   wire logic wr_txc = bus.wr && bus.addr == OFS_TRANSMIT_CONTROL;
   wire logic wr_tick = bus.wr && bus.addr == OFS_MONITOR_TICK;
   wire logic wr_iclr = bus.wr && bus.addr == OFS_IRQ_CLEAR;
   wire logic wr_ien = bus.wr && bus.addr == OFS_IRQ_ENABLE;
   wire logic rd_prbs = bus.rd && bus.addr == OFS_PRBS_COUNT;
   wire logic [2:0] rd_par = {bus.rd && bus.addr == OFS_PATH_COUNT,
                              bus.rd && bus.addr == OFS_LINE_COUNT,
                              bus.rd && bus.addr == OFS_SECTION_COUNT};

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_q <= '0;
         txc_q <= TXC_RESET;
         irq_en_q <= '0;
         inject_q <= 1'b0;
      end
      else
      begin
         if (wr_ctl)
            ctrl_q <= bus.wdata[4:0];
         if (wr_txc)
            txc_q <= bus.wdata;
         if (wr_ien)
            irq_en_q <= bus.wdata[IRQ_W-1:0];
         // single-cycle request; writing zero does nothing
         inject_q <= wr_tick && bus.wdata[TICK_INJECT];
      end
   end

   // =====================================================================
   // pattern sources
   logic [8:0] sq_cnt_q;
   logic sq_lvl_q;
   logic [15:0] mix_q;
   logic [15:0] tss_q;
   logic [6:0] cid_cnt_q;
   logic cid_lvl_q;
   logic [30:0] lfsr_q;
   wire logic prbs_out = lfsr_q[PRBS_TAP_A] ^ lfsr_q[PRBS_TAP_B];
   // toggle once the programmed width has elapsed; zero acts as one
   wire logic sq_wrap = (sq_cnt_q + 9'h001) >= {1'b0, pw};
   wire logic cid_wrap = cid_cnt_q == 7'(CID_RUN - 1);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sq_cnt_q <= '0;
         sq_lvl_q <= 1'b0;
         mix_q <= MIXED_WORD;
         tss_q <= TSS_WORD;
         cid_cnt_q <= '0;
         cid_lvl_q <= 1'b0;
         lfsr_q <= PRBS_SEED;
      end
      else
      begin
         sq_cnt_q <= sq_wrap ? 9'h000 : sq_cnt_q + 9'h001;
         sq_lvl_q <= sq_wrap ? !sq_lvl_q : sq_lvl_q;
         mix_q <= {mix_q[14:0], mix_q[15]};
         // structure pattern rotates a fixed word
         tss_q <= {tss_q[14:0], tss_q[15]};
         // identical digits: long runs of one level, then the other
         cid_cnt_q <= cid_wrap ? 7'h00 : cid_cnt_q + 7'h01;
         cid_lvl_q <= cid_wrap ? !cid_lvl_q : cid_lvl_q;
         // generator state never sees the injected flip
         lfsr_q <= {lfsr_q[29:0], prbs_out};
      end
   end

   // =====================================================================
   // source priority
   // generator enable shadows prbs; prbs shadows tss and cid
   wire wtpg_src_t src_pat = ctrl_q.sq_sel ? SRC_SQUARE : SRC_MIXED;
   wire wtpg_src_t src_low = mode == WTPG_MODE_TSS ? SRC_TSS :
                             mode == WTPG_MODE_CID ? SRC_CID : SRC_LINE;
   // prbs only when the pattern generator is off
   wire wtpg_src_t src_d = ctrl_q.gen_en ? src_pat : ctrl_q.prbs_gen ? SRC_PRBS : src_low;
   logic tx_d;

   always_comb
   begin
      unique case (src_q)
         // square or mixed by the select bit
         SRC_SQUARE: tx_d = sq_lvl_q;
         SRC_MIXED: tx_d = mix_q[15];
         SRC_PRBS: tx_d = prbs_out ^ inject_q;
         SRC_TSS: tx_d = tss_q[15];
         SRC_CID: tx_d = cid_lvl_q;
         SRC_LINE: tx_d = tx_line_bit;
         default: tx_d = tx_line_bit;
      endcase
   end

   // source chosen a cycle ahead so output bit and source stay paired
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         src_q <= SRC_LINE;
         tx_bit_q <= 1'b0;
      end
      else
      begin
         src_q <= src_d;
         tx_bit_q <= tx_d;
      end
   end

   assign tx_test_active = src_q != SRC_LINE;

   // =====================================================================
   // mixed pattern checker
   logic [15:0] rx_hist_q;
   logic mix_err_q;
   // enable gate and no checking of square traffic
   wire logic mix_chk = ctrl_q.chk_en && !ctrl_q.sq_sel;

   always_ff @(posedge ref_clk)
   begin
      if (rst || !mix_chk)
      begin
         rx_hist_q <= '0;
         mix_err_q <= 1'b0;
      end
      else if (rx_valid)
      begin
         // periodic pattern: each bit must equal the bit one period back
         rx_hist_q <= {rx_hist_q[14:0], rx_bit};
         mix_err_q <= rx_bit != rx_hist_q[15];
      end
      else
      begin
         mix_err_q <= 1'b0;
      end
   end

   // section, line and path counters, saturating, cleared on read
   for (genvar i = 0; i < 3; i++)
   begin : g_parity
      always_ff @(posedge ref_clk)
      begin
         if (rst)
            par_cnt_q[i] <= '0;
         else if (rd_par[i])
            par_cnt_q[i] <= {{(CNT_W-1){1'b0}}, mix_err_q};
         else if (mix_err_q && par_cnt_q[i] != CNT_MAX)
            par_cnt_q[i] <= par_cnt_q[i] + 1'b1;
      end
   end

   // =====================================================================
   // prbs checker
   logic prbs_err;
   logic prbs_locked;
   logic locked_d1_q;

   // self-synchronising taps count each injected flip three times
   wtpg_prbs_checker u_chk (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(ctrl_q.prbs_chk),
      .rx_valid(rx_valid),
      .rx_bit(rx_bit),
      .err_q(prbs_err),
      .locked_q(prbs_locked)
   );

   // saturate, clear on read; an error in the read cycle survives
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         prbs_cnt_q <= '0;
      else if (rd_prbs)
         prbs_cnt_q <= {{(CNT_W-1){1'b0}}, prbs_err};
      else if (prbs_err && prbs_cnt_q != CNT_MAX)
         prbs_cnt_q <= prbs_cnt_q + 1'b1;
   end

   // =====================================================================
   // interrupts
   wire logic [IRQ_W-1:0] irq_ev = {mix_err_q, prbs_locked && !locked_d1_q, prbs_err};
   wire logic [IRQ_W-1:0] irq_clr = wr_iclr ? bus.wdata[IRQ_W-1:0] : '0;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         irq_sts_q <= '0;
         locked_d1_q <= 1'b0;
      end
      else
      begin
         // set beats clear in the same cycle
         irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
         locked_d1_q <= prbs_locked;
      end
   end

   assign irq = |(irq_sts_q & irq_en_q);

   // =====================================================================
   // read mux
   logic [DATA_W-1:0] rd_d;

   always_comb
   begin
      rd_d = '0;
      unique case (bus.addr)
         OFS_TEST_CONTROL: rd_d[4:0] = ctrl_q;
         OFS_TEST_STATUS: rd_d[STS_CAPABILITY] = 1'b1;
         OFS_TRANSMIT_CONTROL: rd_d = txc_q;
         OFS_SECTION_COUNT: rd_d = DATA_W'(par_cnt_q[0]);
         OFS_LINE_COUNT: rd_d = DATA_W'(par_cnt_q[1]);
         OFS_PATH_COUNT: rd_d = DATA_W'(par_cnt_q[2]);
         OFS_PRBS_COUNT: rd_d = DATA_W'(prbs_cnt_q);
         OFS_PRBS_STATUS:
         begin
            rd_d[PST_ERROR] = prbs_cnt_q != '0;
            rd_d[PST_LOCKED] = prbs_locked;
         end
         OFS_IRQ_STATUS: rd_d[IRQ_W-1:0] = irq_sts_q;
         OFS_IRQ_ENABLE: rd_d[IRQ_W-1:0] = irq_en_q;
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rdata_q <= '0;
      else
         rdata_q <= bus.rd ? rd_d : '0;
   end

   // =====================================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   square_select_a: assert property (ctrl_q.gen_en && ctrl_q.sq_sel |=> src_q == SRC_SQUARE)
      else $error("square pattern not selected");
   mixed_select_a: assert property (ctrl_q.gen_en && !ctrl_q.sq_sel |=> src_q == SRC_MIXED)
      else $error("mixed pattern not selected");
   gen_off_a: assert property (!ctrl_q.gen_en |=> src_q != SRC_SQUARE && src_q != SRC_MIXED)
      else $error("generator pattern without enable");
   square_width_a: assert property (src_q == SRC_SQUARE && $past(src_q) == SRC_SQUARE
      && $past(src_q, 2) == SRC_SQUARE && $changed(tx_bit_q)
      |-> $past(sq_cnt_q, 2) + 9'h001 >= {1'b0, $past(pw, 2)})
      else $error("square wave toggled early");
   checker_gate_a: assert property (!mix_chk |=> !mix_err_q)
      else $error("mixed checker active while off");
   prbs_prio_a: assert property (ctrl_q.prbs_gen |=> src_q == ($past(ctrl_q.gen_en) ?
      $past(src_pat) : SRC_PRBS))
      else $error("prbs priority wrong");
   count_sat_a: assert property (prbs_cnt_q == CNT_MAX && !rd_prbs |=> prbs_cnt_q == CNT_MAX)
      else $error("prbs counter wrapped");
   count_clear_a: assert property (rd_prbs && !prbs_err |=> prbs_cnt_q == '0)
      else $error("prbs counter not cleared by read");
   error_flag_a: assert property (bus.rd && bus.addr == OFS_PRBS_STATUS
      |=> rdata_q[PST_ERROR] == ($past(prbs_cnt_q) != '0))
      else $error("prbs error flag wrong");
   capability_a: assert property (bus.rd && bus.addr == OFS_TEST_STATUS
      |=> rdata_q[STS_CAPABILITY])
      else $error("capability bit clear");
   inject_flip_a: assert property (src_q == SRC_PRBS
      |=> tx_bit_q == ($past(prbs_out) ^ $past(inject_q)))
      else $error("injected bit not inverted");
   unlocked_off_a: assert property (!ctrl_q.prbs_chk |=> !prbs_locked && !prbs_err)
      else $error("prbs checker active while off");
   parity_count_a: assert property (mix_err_q && !rd_par[0] && par_cnt_q[0] != CNT_MAX
      |=> par_cnt_q[0] == $past(par_cnt_q[0]) + 1'b1)
      else $error("section counter missed error");

   square_seen_c: cover property (src_q == SRC_SQUARE ##1 $changed(tx_bit_q));
   prbs_lock_c: cover property (prbs_locked && src_q == SRC_PRBS);
   prbs_error_c: cover property (prbs_err ##1 prbs_err);
   cid_seen_c: cover property (src_q == SRC_CID && cid_wrap);

endmodule : wtpg_core
`default_nettype wire

// ### tb/wtpg_line_model.sv
// line-side partner of the test pattern block: loops transmit back to receive
// assumes one serial bit per ref_clk in each direction
`timescale 1ns/1ps
`default_nettype none
module wtpg_line_model (
   // clock
   input wire logic ref_clk,
   // transmit line from the block, fault controls from the bench
   input wire logic tx_bit,
   input wire logic flip_one,
   input wire logic invert,
   // receive side of the block
   output var logic rx_valid,
   output var logic rx_bit
);
   // =====
   // loopback path
   initial
   begin
      rx_valid = 1'b0;
      rx_bit = 1'b0;
   end
   // faults only when the bench asks: one flipped bit or a fully inverted stream
   always @(posedge ref_clk)
   begin
      rx_valid <= 1'b1;
      rx_bit <= tx_bit ^ flip_one ^ invert;
   end
endmodule : wtpg_line_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the wan test pattern block, random with a fixed seed
// assumes the line model loops the transmit bit straight back
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import wtpg_pkg::*;
   // counter width kept small so saturation is reached quickly
   localparam int CW = 8;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   wtpg_bus_t bus = '0;
   logic [DATA_W-1:0] rdata_q;
   logic tx_line_bit = 1'b0;
   logic tx_bit_q, tx_test_active, rx_valid, rx_bit, irq;
   logic flip_one = 1'b0;
   logic invert = 1'b0;
   logic bits [0:511];
   int nb;
   integer seed = 32'hcd45e45f;
   int bad_count = 0;
   int check_count = 0;
   int w, k;
   logic [15:0] d;

   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) tx_line_bit <= 1'($random(seed));

   wtpg_core #(.CNT_W(CW)) i_dut (.ref_clk, .rst, .bus, .rdata_q, .tx_line_bit,
      .tx_bit_q, .tx_test_active, .rx_valid, .rx_bit, .irq);
   wtpg_line_model i_line (.ref_clk(ref_clk), .tx_bit(tx_bit_q), .flip_one(flip_one),
      .invert(invert), .rx_valid(rx_valid), .rx_bit(rx_bit));

   // =====
   // helpers
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus <= '0;
   endtask : wr

   // an empty name reads without comparing, used to clear counters
   task automatic rc(input logic [7:0] a, input logic [15:0] e, input string n);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus <= '0;
      #1;
      if (n != "")
         chk(n, e, rdata_q);
   endtask : rc

   task automatic grab(input int n);
      nb = n;
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk);
         #1;
         bits[i] = tx_bit_q;
      end
   endtask : grab

   // periodic pattern: repeats every p bits with a known count of ones
   task automatic per(input string n, input int p, input int ones);
      int e = 0;
      int o = 0;
      for (int i = 0; i < nb - p; i++)
         if (bits[i] !== bits[i + p])
            e++;
      for (int i = 0; i < p; i++)
         if (bits[i] === 1'b1)
            o++;
      chk(n, 16'(ones), 16'(o));
      chk(n, 16'h0000, 16'(e));
      chk("test active", 16'h0001, {15'h0000, tx_test_active});
   endtask : per

   // bits breaking b[n] = b[n-31] ^ b[n-28]
   function automatic int prbs_viol();
      int v = 0;
      for (int i = 31; i < nb; i++)
         if (bits[i] !== (bits[i - 31] ^ bits[i - 28]))
            v++;
      return v;
   endfunction : prbs_viol

   // =====
   // watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      final_report();
   end

   // =====
   // main sequence
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rc(OFS_TEST_STATUS, 16'h0001, "capability");
      rc(OFS_TRANSMIT_CONTROL, TXC_RESET, "txc reset");
      wr(OFS_TEST_STATUS, 16'h0000);
      rc(OFS_TEST_STATUS, 16'h0001, "capability ro");
      rc(8'h3f, 16'h0000, "unmapped");
      // generator off: random line bits pass one cycle later
      k = 0;
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < 32; i++)
      begin
         d[0] = tx_line_bit;
         @(posedge ref_clk);
         #1;
         if (tx_bit_q !== d[0])
            k++;
      end
      chk("line pass", 16'h0000, 16'(k));
      chk("idle active", 16'h0000, {15'h0000, tx_test_active});
      // square wave, zero width corner then a random width, prbs also requested
      for (int j = 0; j < 2; j++)
      begin
         w = (j == 0) ? 0 : 1 + ($unsigned($random(seed)) % 12);
         wr(OFS_TRANSMIT_CONTROL, 16'(w));
         wr(OFS_TEST_CONTROL, 16'h000b);
         repeat (4) @(posedge ref_clk);
         grab(100);
         per("square", (w == 0) ? 2 : 2 * w, (w == 0) ? 1 : w);
      end
      wr(OFS_TEST_CONTROL, 16'h000a);
      repeat (4) @(posedge ref_clk);
      grab(100);
      per("mixed", 16, 8);
      wr(OFS_TEST_CONTROL, 16'h0000);
      wr(OFS_TRANSMIT_CONTROL, 16'h0104);
      repeat (4) @(posedge ref_clk);
      grab(100);
      per("tss", 16, 8);
      wr(OFS_TRANSMIT_CONTROL, 16'h0204);
      repeat (4) @(posedge ref_clk);
      grab(400);
      per("cid", 144, 72);
      wr(OFS_TRANSMIT_CONTROL, 16'h0004);
      // prbs loopback, lock, one injected error
      wr(OFS_TEST_CONTROL, 16'h0018);
      repeat (100) @(posedge ref_clk);
      rc(OFS_PRBS_STATUS, 16'h0002, "locked clean");
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(OFS_IRQ_ENABLE, 16'h0001);
      fork
         grab(150);
         begin
            // flip lands past bit 31 so all three recurrence breaks fall inside the grab
            repeat (40) @(posedge ref_clk);
            wr(OFS_MONITOR_TICK, 16'h0001);
         end
      join
      chk("one flip", 16'h0003, 16'(prbs_viol()));
      repeat (50) @(posedge ref_clk);
      chk("irq raised", 16'h0001, {15'h0000, irq});
      rc(OFS_PRBS_STATUS, 16'h0003, "err flag");
      rc(OFS_PRBS_COUNT, 16'h0003, "three errors");
      rc(OFS_PRBS_COUNT, 16'h0000, "clear on read");
      rc(OFS_PRBS_STATUS, 16'h0002, "err flag clear");
      rc(OFS_IRQ_STATUS, 16'h0003, "irq status");
      wr(OFS_IRQ_CLEAR, 16'h0003);
      rc(OFS_IRQ_STATUS, 16'h0000, "irq cleared");
      chk("irq low", 16'h0000, {15'h0000, irq});
      // inverted stream: every bit wrong, counter must stop at its top
      invert <= 1'b1;
      repeat (300) @(posedge ref_clk);
      rc(OFS_PRBS_COUNT, 16'((1 << CW) - 1), "saturated");
      wr(OFS_TEST_CONTROL, 16'h0008);
      repeat (5) @(posedge ref_clk);
      rc(OFS_PRBS_COUNT, 16'h0000, "");
      repeat (50) @(posedge ref_clk);
      rc(OFS_PRBS_COUNT, 16'h0000, "checker off");
      rc(OFS_PRBS_STATUS, 16'h0000, "lock lost");
      invert <= 1'b0;
      // mixed checker on, off, and on with square wave selected
      for (int j = 0; j < 3; j++)
      begin
         wr(OFS_TEST_CONTROL, (j == 0) ? 16'h0006 : (j == 1) ? 16'h0002 : 16'h0007);
         repeat (40) @(posedge ref_clk);
         for (int a = 0; a < 3; a++)
            rc(OFS_SECTION_COUNT + 8'(a), 16'h0000, "");
         @(posedge ref_clk);
         flip_one <= 1'b1;
         @(posedge ref_clk);
         flip_one <= 1'b0;
         repeat (40) @(posedge ref_clk);
         for (int a = 0; a < 3; a++)
            rc(OFS_SECTION_COUNT + 8'(a), (j == 0) ? 16'h0002 : 16'h0000, "parity");
      end
      final_report();
   end
endmodule : tb_top
`default_nettype wire
